// ===== ecc_pkg.sv
`default_nettype none

package ecc_pkg;

    // Parallel port register offsets
    localparam logic [7:0] ECC_CTL1_ADDR   = 8'h14;
    localparam logic [7:0] ECC_CTL2_ADDR   = 8'h1A;
    localparam logic [7:0] ECC_CTL3_ADDR   = 8'h1B;
    localparam logic [7:0] ECC_STATUS_ADDR = 8'h1C;

    // Reset values and write mask
    localparam logic [7:0] ECC_CTL1_RST  = 8'h00;
    localparam logic [7:0] ECC_CTL2_RST  = 8'h00;
    localparam logic [7:0] ECC_CTL3_RST  = 8'h00;
    localparam logic [7:0] ECC_CTL3_WMASK = 8'hFA;

    // common_control_one
    localparam int ECC_FLOOP_BIT   = 7;
    // common_control_two
    localparam int ECC_UPDSEL_BIT  = 7;
    localparam int ECC_VTYPE_BIT   = 6;
    localparam int ECC_AUTOAIS_BIT = 5;
    localparam int ECC_AUTORAI_BIT = 4;
    localparam int ECC_RSFC_BIT    = 3;
    localparam int ECC_TXFO_BIT    = 2;
    localparam int ECC_RLOOP_BIT   = 1;
    localparam int ECC_LLOOP_BIT   = 0;
    // common_control_three
    localparam int ECC_TXES_BIT   = 7;
    localparam int ECC_TCBF_BIT   = 6;
    localparam int ECC_TIRF_BIT   = 5;
    localparam int ECC_ESRST_BIT  = 4;
    localparam int ECC_LIR_BIT    = 3;
    localparam int ECC_TBCK_BIT   = 1;
    // Status register of the block
    localparam int ECC_ST_TXLOST_BIT = 0;
    localparam int ECC_ST_TXSRC_BIT  = 1;
    localparam int ECC_ST_LIBUSY_BIT = 2;
    localparam int ECC_ST_ALARM_BIT  = 3;

    // Timing
    localparam int ECC_CLK_NS        = 10;
    localparam int ECC_UPD_SLOW_MS   = 1000;
    localparam int ECC_UPD_FAST_US   = 62500;
    localparam int ECC_LI_RECOVER_MS = 40;
    localparam int ECC_TXCLK_LOSS_NS = 1000;
    localparam int ECC_UPD_SLOW_CYC  = ECC_UPD_SLOW_MS * 1000000 / ECC_CLK_NS;
    localparam int ECC_UPD_FAST_CYC  = ECC_UPD_FAST_US * 1000 / ECC_CLK_NS;
    localparam int ECC_LI_RECOV_CYC  = ECC_LI_RECOVER_MS * 1000000 / ECC_CLK_NS;
    localparam int ECC_TXCLK_LOSS_CYC = ECC_TXCLK_LOSS_NS / ECC_CLK_NS;

    localparam int ECC_CNT_W  = 27;
    localparam int ECC_IDLE_W = 12;

    typedef struct packed {
        logic pos;
        logic neg;
    } ecc_line_t;

    typedef struct packed {
        logic [7:0]           ctl1;
        logic [7:0]           ctl2;
        logic [7:0]           ctl3;
        logic [7:0]           rdata;
        logic [ECC_CNT_W-1:0] upd_cnt;
        logic                 upd_fast;
        logic                 upd_stb;
        logic [ECC_CNT_W-1:0] li_cnt;
        logic                 li_busy;
        logic                 li_rst;
        logic                 es_rst;
        logic                 tx_clock_in_prev;
        logic [ECC_IDLE_W-1:0] idle_cnt;
        logic                 tx_clock_in_lost;
        ecc_line_t            line_tx;
        ecc_line_t            ja_feed;
        ecc_line_t            rx_framer;
        logic                 rx_clk;
        logic                 fmt_clk;
        logic                 viol_evt;
        logic                 send_ais;
        logic                 send_rai;
    } ecc_state_t;

endpackage : ecc_pkg

`default_nettype wire

// ===== ecc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ecc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clock_in,
    input  wire logic         sys_rst_in,
    // Data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : ecc_sync

`default_nettype wire

// ===== ecc_skid.sv
`timescale 1ns/1ps
`default_nettype none

module ecc_skid #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clock_in,
    input  wire logic         sys_rst_in,
    // Fill side
    input  wire logic         in_valid_in,
    input  wire logic [W-1:0] in_data_in,
    output logic              in_ready_out,
    // Drain side
    output logic              out_valid_out,
    output logic      [W-1:0] out_data_out,
    input  wire logic         out_ready_in
);
    typedef struct packed {
        logic         out_v;
        logic [W-1:0] out_d;
        logic         sp_v;
        logic [W-1:0] sp_d;
        logic         rdy;
    } ecc_skid_t;

    ecc_skid_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        if (s_q.out_v && out_ready_in) begin
            s_d.out_v = s_q.sp_v;
            s_d.out_d = s_q.sp_d;
            s_d.sp_v  = 1'b0;
        end
        // Ready is registered, so the spare entry absorbs one late word
        if (in_valid_in && s_q.rdy) begin
            if (!s_d.out_v) begin
                s_d.out_v = 1'b1;
                s_d.out_d = in_data_in;
            end else begin
                s_d.sp_v = 1'b1;
                s_d.sp_d = in_data_in;
            end
        end
        s_d.rdy = !s_d.sp_v;
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            s_q <= '{out_v: 1'b0, out_d: '0, sp_v: 1'b0, sp_d: '0, rdy: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign in_ready_out  = s_q.rdy;
    assign out_valid_out = s_q.out_v;
    assign out_data_out  = s_q.out_d;

    chk_skid_no_overrun: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (s_q.sp_v && !out_ready_in) |=> !s_q.rdy)
        else $error("skid buffer accepted a word while full");
endmodule : ecc_skid

`default_nettype wire

// ===== ecc_common_ctrl.sv
// Function
// - Counter update strobe every second, or every 62.5 ms when selected.
// - Violation event is bipolar violation at 0, code violation at 1.
// - Receive serial output forced high on frame loss when enabled.
// - Transmit formatter falls over to recovered clock if transmit clock stops.
// - Local loopback feeds transmitted data into receive jitter attenuator.
// - Remote loopback retransmits recovered line data, formatter data ignored.
// - Framer loopback feeds transmit data to receive side, line input ignored.
// - Framer loopback drives receive clock from the transmit clock.
// - Frame loss, AIS or signal loss triggers automatic AIS or remote alarm.
// - Transmit elastic store bypassed at 0, active at 1.
// - Channel block function select steers block pin or signaling insert.
// - Idle function select chooses idle code or receive data insert.
// - Falling edge of elastic store reset bit resets both stores once.
// - Rising edge of line interface reset bit resets the line interface.
// - Line interface needs about 40 ms to recover after reset.
// - Backplane clock select: 0 is 1.544 MHz, 1 is 2.048 MHz.
`timescale 1ns/1ps
`default_nettype none

module ecc_common_ctrl
    import ecc_pkg::*;
#(
    parameter int UPD_SLOW_CYC = ECC_UPD_SLOW_CYC,
    parameter int UPD_FAST_CYC = ECC_UPD_FAST_CYC,
    parameter int LI_RECOV_CYC = ECC_LI_RECOV_CYC
) (
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       sys_rst_in,
    // Parallel port
    input  wire logic [7:0] bus_addr_in,
    input  wire logic [7:0] bus_wdata_in,
    input  wire logic       bus_wr_in,
    input  wire logic       bus_rd_in,
    output logic      [7:0] bus_rdata_out,
    // Pins
    input  wire ecc_line_t  line_rx_in,
    input  wire logic       tx_clock_in,
    input  wire logic       recovered_clock_in,
    // Framer and jitter attenuator side
    input  wire ecc_line_t  fmt_tx_in,
    input  wire ecc_line_t  ja_return_in,
    input  wire logic       loss_of_frame_in,
    input  wire logic       ais_detect_in,
    input  wire logic       loss_of_signal_in,
    input  wire logic       bpv_event_in,
    input  wire logic       cv_event_in,
    // Receive serial stream
    input  wire logic       rx_bit_valid_in,
    input  wire logic       rx_bit_in,
    output logic            rx_bit_ready_out,
    output logic            rx_serial_valid_out,
    output logic            rx_serial_out,
    input  wire logic       rx_serial_ready_in,
    // Line and clock outputs
    output ecc_line_t       line_tx_out,
    output ecc_line_t       ja_feed_out,
    output ecc_line_t       rx_framer_out,
    output logic            rx_clock_out,
    output logic            tx_fmt_clock_out,
    // Control outputs
    output logic            counter_update_stb_out,
    output logic            violation_event_out,
    output logic            send_ais_out,
    output logic            send_remote_alarm_out,
    output logic            tx_es_enable_out,
    output logic            tx_chan_block_func_out,
    output logic            tx_idle_func_out,
    output logic            es_reset_out,
    output logic            li_reset_out,
    output logic            li_recovering_out,
    output logic            tx_backplane_2048_out
);
    ecc_state_t s_q, s_d;
    ecc_line_t  line_rx_s;
    logic [1:0] clk_s;
    logic       tx_clock_in_s, rclk_s, alarm_cond, rx_bit_fix;

    ecc_sync #(.W(4)) u_pin_sync (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .async_in   ({line_rx_in, tx_clock_in, recovered_clock_in}),
        .sync_out   ({line_rx_s, clk_s})
    );
    assign tx_clock_in_s = clk_s[1];
    assign rclk_s = clk_s[0];

    function automatic logic [ECC_CNT_W-1:0] cyc_limit(input int n);
        return ECC_CNT_W'(n - 1);
    endfunction

    assign alarm_cond = loss_of_frame_in | ais_detect_in | loss_of_signal_in;
    // Forced to 1 while frame alignment is lost
    assign rx_bit_fix = rx_bit_in |
        (s_q.ctl2[ECC_RSFC_BIT] & loss_of_frame_in);

    ecc_skid #(.W(1)) u_rx_buf (
        .clock_in      (clock_in),
        .sys_rst_in    (sys_rst_in),
        .in_valid_in   (rx_bit_valid_in),
        .in_data_in    (rx_bit_fix),
        .in_ready_out  (rx_bit_ready_out),
        .out_valid_out (rx_serial_valid_out),
        .out_data_out  (rx_serial_out),
        .out_ready_in  (rx_serial_ready_in)
    );

    always_comb begin
        s_d         = s_q;
        s_d.upd_stb = 1'b0;
        s_d.li_rst  = 1'b0;
        s_d.es_rst  = 1'b0;

        // Register writes and reads
        if (bus_wr_in) begin
            unique case (bus_addr_in)
                ECC_CTL1_ADDR: s_d.ctl1 = bus_wdata_in;
                ECC_CTL2_ADDR: s_d.ctl2 = bus_wdata_in;
                ECC_CTL3_ADDR: s_d.ctl3 = bus_wdata_in & ECC_CTL3_WMASK;
                default: ;
            endcase
        end
        if (bus_rd_in) begin
            unique case (bus_addr_in)
                ECC_CTL1_ADDR:   s_d.rdata = s_q.ctl1;
                ECC_CTL2_ADDR:   s_d.rdata = s_q.ctl2;
                ECC_CTL3_ADDR:   s_d.rdata = s_q.ctl3;
                ECC_STATUS_ADDR: s_d.rdata = {4'h0, alarm_cond, s_q.li_busy,
                                   s_q.ctl2[ECC_TXFO_BIT] & s_q.tx_clock_in_lost,
                                   s_q.tx_clock_in_lost};
                default:         s_d.rdata = 8'h00;
            endcase
        end

        // A select change restarts the period so no short interval occurs
        s_d.upd_fast = s_q.ctl2[ECC_UPDSEL_BIT];
        if (s_q.upd_fast != s_q.ctl2[ECC_UPDSEL_BIT]) begin
            s_d.upd_cnt = '0;
        end else if (s_q.upd_cnt == (s_q.upd_fast ? cyc_limit(UPD_FAST_CYC)
                                     : cyc_limit(UPD_SLOW_CYC))) begin
            s_d.upd_cnt = '0;
            s_d.upd_stb = 1'b1;
        end else begin
            s_d.upd_cnt = s_q.upd_cnt + 1'b1;
        end

        s_d.viol_evt = s_q.ctl2[ECC_VTYPE_BIT] ? cv_event_in
                                               : bpv_event_in;

        // Edge-triggered resets act on the stored bit history
        if (s_q.ctl3[ECC_ESRST_BIT] && !s_d.ctl3[ECC_ESRST_BIT]) begin
            s_d.es_rst = 1'b1;
        end
        if (!s_q.ctl3[ECC_LIR_BIT] && s_d.ctl3[ECC_LIR_BIT]) begin
            s_d.li_rst  = 1'b1;
            s_d.li_busy = 1'b1;
            s_d.li_cnt  = '0;
        end else if (s_q.li_busy) begin
            if (s_q.li_cnt == cyc_limit(LI_RECOV_CYC)) begin
                s_d.li_busy = 1'b0;
            end else begin
                s_d.li_cnt = s_q.li_cnt + 1'b1;
            end
        end

        // Transmit clock watchdog on the synchronised clock level
        s_d.tx_clock_in_prev = tx_clock_in_s;
        if (tx_clock_in_s != s_q.tx_clock_in_prev) begin
            s_d.idle_cnt  = '0;
            s_d.tx_clock_in_lost = 1'b0;
        end else if (s_q.idle_cnt == ECC_IDLE_W'(ECC_TXCLK_LOSS_CYC - 1)) begin
            s_d.tx_clock_in_lost = 1'b1;
        end else begin
            s_d.idle_cnt = s_q.idle_cnt + 1'b1;
        end
        s_d.fmt_clk = (s_q.ctl2[ECC_TXFO_BIT] && s_q.tx_clock_in_lost) ? rclk_s
                                                                : tx_clock_in_s;
        s_d.rx_clk = s_q.ctl1[ECC_FLOOP_BIT] ? tx_clock_in_s : rclk_s;

        // Loopback muxing
        s_d.ja_feed = s_q.ctl2[ECC_LLOOP_BIT] ? fmt_tx_in : line_rx_s;
        s_d.line_tx = s_q.ctl2[ECC_RLOOP_BIT] ? ja_return_in
                                              : fmt_tx_in;
        s_d.rx_framer = s_q.ctl1[ECC_FLOOP_BIT] ? fmt_tx_in
                                                : ja_return_in;

        s_d.send_ais = s_q.ctl2[ECC_AUTOAIS_BIT] & alarm_cond;
        s_d.send_rai = s_q.ctl2[ECC_AUTORAI_BIT] & ~s_q.ctl2[ECC_AUTOAIS_BIT]
                       & alarm_cond;
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            s_q      <= '0;
            s_q.ctl1 <= ECC_CTL1_RST;
            s_q.ctl2 <= ECC_CTL2_RST;
            s_q.ctl3 <= ECC_CTL3_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus_rdata_out          = s_q.rdata;
    assign line_tx_out            = s_q.line_tx;
    assign ja_feed_out            = s_q.ja_feed;
    assign rx_framer_out          = s_q.rx_framer;
    assign rx_clock_out           = s_q.rx_clk;
    assign tx_fmt_clock_out       = s_q.fmt_clk;
    assign counter_update_stb_out = s_q.upd_stb;
    assign violation_event_out    = s_q.viol_evt;
    assign send_ais_out           = s_q.send_ais;
    assign send_remote_alarm_out  = s_q.send_rai;
    assign tx_es_enable_out       = s_q.ctl3[ECC_TXES_BIT];
    assign tx_chan_block_func_out = s_q.ctl3[ECC_TCBF_BIT];
    assign tx_idle_func_out       = s_q.ctl3[ECC_TIRF_BIT];
    assign es_reset_out           = s_q.es_rst;
    assign li_reset_out           = s_q.li_rst;
    assign li_recovering_out      = s_q.li_busy;
    assign tx_backplane_2048_out  = s_q.ctl3[ECC_TBCK_BIT];

    chk_update_period_fast: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (s_q.upd_stb && s_q.upd_fast && $stable(s_q.upd_fast))
        |-> $past(s_q.upd_cnt) == cyc_limit(UPD_FAST_CYC))
        else $error("counter update strobe off period");
    chk_viol_select: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (s_q.ctl2[ECC_VTYPE_BIT] && cv_event_in && $stable(s_q.ctl2))
        |=> violation_event_out)
        else $error("code violation not passed");
    chk_framer_loop_data: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        s_q.ctl1[ECC_FLOOP_BIT] && !bus_wr_in
        |=> rx_framer_out == $past(fmt_tx_in))
        else $error("framer loopback data wrong");
    chk_remote_loop_data: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        s_q.ctl2[ECC_RLOOP_BIT] && !bus_wr_in
        |=> line_tx_out == $past(ja_return_in))
        else $error("remote loopback data wrong");
    chk_local_loop_data: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        s_q.ctl2[ECC_LLOOP_BIT] && !bus_wr_in
        |=> ja_feed_out == $past(fmt_tx_in))
        else $error("local loopback data wrong");
    chk_alarm_priority: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        !(send_ais_out && send_remote_alarm_out))
        else $error("both alarms sent together");
    chk_es_reset_edge: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        es_reset_out |-> $past(s_q.ctl3[ECC_ESRST_BIT])
                         && !s_q.ctl3[ECC_ESRST_BIT])
        else $error("elastic store reset without falling edge");
    chk_li_reset_edge: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        li_reset_out |=> !li_reset_out && li_recovering_out)
        else $error("line reset pulse malformed");
    chk_rx_force_one: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        (rx_bit_valid_in && rx_bit_ready_out && loss_of_frame_in
         && s_q.ctl2[ECC_RSFC_BIT] && !rx_serial_valid_out)
        |=> rx_serial_out)
        else $error("receive serial not forced high");
endmodule : ecc_common_ctrl

`default_nettype wire

// ===== ecc_line_model.sv
`timescale 1ns/1ps
`default_nettype none

module ecc_line_model
    import ecc_pkg::*;
(
    // Clock
    input  wire logic      clock_in,
    // Control from the bench
    input  wire logic      tx_clock_in_run_in,
    // Jitter attenuator
    input  wire ecc_line_t ja_feed_in,
    output ecc_line_t      ja_return_out,
    // Line clocks
    output logic           tx_clock_out,
    output logic           recovered_clock_out
);
    logic [2:0] div_q = 3'h0;

    // Attenuator passes data one cycle late, violations untouched
    always @(posedge clock_in) begin
        div_q <= div_q + 3'h1;
        ja_return_out <= ja_feed_in;
    end

    // Recovered clock never stops; the transmit clock stalls low on demand
    assign recovered_clock_out = div_q[2];
    assign tx_clock_out        = tx_clock_in_run_in & div_q[2];
endmodule // ecc_line_model

`default_nettype wire

// ===== test_e1_common_control_loopback.sv
`timescale 1ns/1ps
`default_nettype none

module test_e1_common_control_loopback;
    import ecc_pkg::*;
    logic       clock_in, sys_rst_in, bus_wr_in, bus_rd_in, tx_clock_in_run, f;
    logic       tx_clock_in, recovered_clock_in, acc;
    logic [7:0] bus_addr_in, bus_wdata_in, bus_rdata_out, rv, d;
    ecc_line_t  line_rx_in, fmt_tx_in, ja_return_in;
    ecc_line_t  line_tx_out, ja_feed_out, rx_framer_out;
    logic       loss_of_frame_in, ais_detect_in, loss_of_signal_in;
    logic       bpv_event_in, cv_event_in, rx_bit_valid_in, rx_bit_in;
    logic       rx_bit_ready_out, rx_serial_valid_out, rx_serial_out;
    logic       rx_serial_ready_in, rx_clock_out, tx_fmt_clock_out;
    logic       counter_update_stb_out, violation_event_out, send_ais_out;
    logic       send_remote_alarm_out, tx_es_enable_out, tx_idle_func_out;
    logic       tx_chan_block_func_out, es_reset_out, li_reset_out;
    logic       li_recovering_out, tx_backplane_2048_out;
    int         err_total, checks, cyc, n_v, n_es, n_li, n;
    logic [31:0] seed;
    logic       q[$];
    logic [7:0] modes[4] = '{8'h00, 8'h20, 8'h10, 8'h30};

    ecc_common_ctrl #(.UPD_SLOW_CYC(50), .UPD_FAST_CYC(20),
        .LI_RECOV_CYC(30)) DUT (
        .clock_in, .sys_rst_in, .bus_addr_in, .bus_wdata_in, .bus_wr_in,
        .bus_rd_in, .bus_rdata_out, .line_rx_in, .tx_clock_in,
        .recovered_clock_in, .fmt_tx_in, .ja_return_in, .loss_of_frame_in,
        .ais_detect_in, .loss_of_signal_in, .bpv_event_in, .cv_event_in,
        .rx_bit_valid_in, .rx_bit_in, .rx_bit_ready_out,
        .rx_serial_valid_out, .rx_serial_out, .rx_serial_ready_in,
        .line_tx_out, .ja_feed_out, .rx_framer_out, .rx_clock_out,
        .tx_fmt_clock_out, .counter_update_stb_out, .violation_event_out,
        .send_ais_out, .send_remote_alarm_out, .tx_es_enable_out,
        .tx_chan_block_func_out, .tx_idle_func_out, .es_reset_out,
        .li_reset_out, .li_recovering_out, .tx_backplane_2048_out);

    ecc_line_model PARTNER (.clock_in, .tx_clock_in_run_in(tx_clock_in_run),
        .ja_feed_in(ja_feed_out), .ja_return_out(ja_return_in),
        .tx_clock_out(tx_clock_in), .recovered_clock_out(recovered_clock_in));

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    always @(posedge clock_in) begin
        n_v += int'(violation_event_out);
        n_es += int'(es_reset_out);
        n_li += int'(li_reset_out);
        cyc++;
        if (cyc > 20000) begin
            err_total++;
            conclude();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Alarm the device should raise for a given second control byte
    function automatic logic [1:0] alarm_exp(logic [7:0] m, logic cond);
        return {cond & m[ECC_AUTOAIS_BIT],
                cond & m[ECC_AUTORAI_BIT] & ~m[ECC_AUTOAIS_BIT]};
    endfunction

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge clock_in);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        bus_addr_in = a;
        bus_wdata_in = v;
        bus_wr_in = 1'b1;
        step(1);
        bus_wr_in = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        bus_addr_in = a;
        bus_rd_in = 1'b1;
        step(1);
        bus_rd_in = 1'b0;
        step(1);
        v = bus_rdata_out;
    endtask

    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic cmpb(input logic g, input logic e);
        cmp({7'h00, g}, {7'h00, e});
    endtask

    task automatic gap(output int k);
        k = 0;
        do begin
            step(1);
            k++;
        end while (counter_update_stb_out !== 1'b1 && k < 200);
    endtask

    // Fill against a stalled receiver, then drain and check order
    task automatic stream(input logic force_one);
        rx_serial_ready_in = 1'b0;
        repeat (4) begin
            rx_bit_valid_in = 1'b1;
            rx_bit_in = 1'(rnd());
            if (rx_bit_ready_out === 1'b1)
                q.push_back(force_one | rx_bit_in);
            step(1);
        end
        rx_bit_valid_in = 1'b0;
        cmp(8'(q.size()), 8'h02);
        rx_serial_ready_in = 1'b1;
        repeat (6) begin
            if (rx_serial_valid_out === 1'b1)
                cmpb(rx_serial_out, q.size() ? q.pop_front() : ~rx_serial_out);
            step(1);
        end
        cmp(8'(q.size()), 8'h00);
    endtask

    initial begin
        {bus_wr_in, bus_rd_in, bus_addr_in, bus_wdata_in} = 18'h0;
        {line_rx_in, fmt_tx_in, loss_of_frame_in, ais_detect_in} = 6'h0;
        {loss_of_signal_in, bpv_event_in, cv_event_in} = 3'h0;
        {rx_bit_valid_in, rx_bit_in, rx_serial_ready_in} = 3'h0;
        {err_total, checks, cyc, n_v, n_es, n_li} = '0;
        seed = 32'd76913;
        tx_clock_in_run = 1'b1;
        sys_rst_in = 1'b1;
        repeat (8) @(posedge clock_in);
        #1 sys_rst_in = 1'b0;
        step(1);
        rd(ECC_CTL2_ADDR, rv);
        cmp(rv, ECC_CTL2_RST);
        wr(ECC_CTL1_ADDR, 8'h00);
        wr(ECC_CTL2_ADDR, 8'h00);
        wr(8'h33, 8'hA5);
        rd(8'h33, rv);
        cmp(rv, 8'h00);
        wr(ECC_CTL3_ADDR, 8'hFF);
        rd(ECC_CTL3_ADDR, rv);
        cmp(rv, 8'hFA);
        for (int i = 0; i < 6; i++) begin
            d = 8'(rnd());
            if (d[ECC_AUTOAIS_BIT]) d[ECC_AUTORAI_BIT] = 1'b0;
            wr(ECC_CTL2_ADDR, d);
            rd(ECC_CTL2_ADDR, rv);
            cmp(rv, d);
            d = 8'(rnd()) & 8'hEA;
            wr(ECC_CTL3_ADDR, d);
            rd(ECC_CTL3_ADDR, rv);
            cmp(rv, d);
            cmpb(tx_es_enable_out, d[ECC_TXES_BIT]);
            cmpb(tx_chan_block_func_out, d[ECC_TCBF_BIT]);
            cmpb(tx_idle_func_out, d[ECC_TIRF_BIT]);
            cmpb(tx_backplane_2048_out, d[ECC_TBCK_BIT]);
        end
        wr(ECC_CTL3_ADDR, 8'h00);
        $display("registers done");
        for (int i = 0; i < 3; i++) begin
            {fmt_tx_in, line_rx_in} = 4'(rnd());
            wr(ECC_CTL2_ADDR, 8'h01);
            step(8);
            cmp(8'(ja_feed_out), 8'(fmt_tx_in));
            cmp(8'(line_tx_out), 8'(fmt_tx_in));
            wr(ECC_CTL2_ADDR, 8'h02);
            step(8);
            cmp(8'(line_tx_out), 8'(line_rx_in));
            wr(ECC_CTL2_ADDR, 8'h00);
            wr(ECC_CTL1_ADDR, 8'h80);
            step(8);
            cmp(8'(rx_framer_out), 8'(fmt_tx_in));
            cmp(8'(line_tx_out), 8'(fmt_tx_in));
        end
        // Stalled transmit clock must leave the receive clock still
        tx_clock_in_run = 1'b0;
        step(5);
        acc = 1'b0;
        repeat (16) begin
            acc |= rx_clock_out;
            step(1);
        end
        cmpb(acc, 1'b0);
        tx_clock_in_run = 1'b1;
        wr(ECC_CTL1_ADDR, 8'h00);
        $display("loopbacks done");
        foreach (modes[m]) begin
            wr(ECC_CTL2_ADDR, modes[m]);
            for (int k = 0; k < 3; k++) begin
                {loss_of_signal_in, ais_detect_in, loss_of_frame_in} = 3'h1 << k;
                step(5);
                cmp(8'({send_ais_out, send_remote_alarm_out}),
                    8'(alarm_exp(modes[m], 1'b1)));
                {loss_of_signal_in, ais_detect_in, loss_of_frame_in} = 3'h0;
                step(5);
                cmp(8'({send_ais_out, send_remote_alarm_out}), 8'h00);
            end
        end
        $display("alarms done");
        for (int s = 0; s < 2; s++) begin
            wr(ECC_CTL2_ADDR, s ? 8'h40 : 8'h00);
            n_v = 0;
            bpv_event_in = 1'b1;
            step(1);
            bpv_event_in = 1'b0;
            step(4);
            cmp(8'(n_v), s ? 8'h00 : 8'h01);
            n_v = 0;
            cv_event_in = 1'b1;
            step(1);
            cv_event_in = 1'b0;
            step(4);
            cmp(8'(n_v), s ? 8'h01 : 8'h00);
        end
        wr(ECC_CTL2_ADDR, 8'h80);
        gap(n);
        gap(n);
        cmp(8'(n), 8'd20);
        wr(ECC_CTL2_ADDR, 8'h00);
        gap(n);
        gap(n);
        cmp(8'(n), 8'd50);
        $display("counters done");
        n_es = 0;
        wr(ECC_CTL3_ADDR, 8'h10);
        wr(ECC_CTL3_ADDR, 8'h00);
        step(3);
        cmp(8'(n_es), 8'h01);
        wr(ECC_CTL3_ADDR, 8'h00);
        step(3);
        cmp(8'(n_es), 8'h01);
        n_li = 0;
        wr(ECC_CTL3_ADDR, 8'h08);
        step(3);
        cmpb(li_recovering_out, 1'b1);
        step(35);
        cmpb(li_recovering_out, 1'b0);
        wr(ECC_CTL3_ADDR, 8'h08);
        step(3);
        cmp(8'(n_li), 8'h01);
        wr(ECC_CTL3_ADDR, 8'h00);
        wr(ECC_CTL3_ADDR, 8'h08);
        step(3);
        cmp(8'(n_li), 8'h02);
        wr(ECC_CTL3_ADDR, 8'h00);
        $display("resets done");
        stream(1'b0);
        wr(ECC_CTL2_ADDR, 8'h08);
        loss_of_frame_in = 1'b1;
        stream(1'b1);
        loss_of_frame_in = 1'b0;
        $display("stream done");
        wr(ECC_CTL2_ADDR, 8'h04);
        tx_clock_in_run = 1'b0;
        step(150);
        rd(ECC_STATUS_ADDR, rv);
        cmp(rv & 8'h03, 8'h03);
        // Formatter clock must keep toggling from the recovered clock
        acc = 1'b0;
        repeat (16) begin
            acc |= tx_fmt_clock_out;
            step(1);
        end
        cmpb(acc, 1'b1);
        wr(ECC_CTL2_ADDR, 8'h00);
        step(3);
        rd(ECC_STATUS_ADDR, rv);
        cmp(rv & 8'h03, 8'h01);
        tx_clock_in_run = 1'b1;
        step(20);
        rd(ECC_STATUS_ADDR, rv);
        cmp(rv & 8'h01, 8'h00);
        $display("failover done");
        conclude();
    end
endmodule // test_e1_common_control_loopback

`default_nettype wire
